// *** inc/port9_params.svh ***
// Offsets, reset values and field positions for the port 9 pin function block
`ifndef PORT9_PARAMS_SVH
`define PORT9_PARAMS_SVH
// ****************************************
// Register offsets (index; byte address is four times this)
// ****************************************
`define PORT9_IDX_LATCH       8'h19
`define PORT9_IDX_DIRECTION   8'h1c
`define PORT9_IDX_FUNCTION    8'h1d
`define PORT9_IDX_OPEN_DRAIN  8'h1e
`define PORT9_IDX_OSC_CTRL    8'h1f
// ****************************************
// Reset values
// ****************************************
`define PORT9_RST_LATCH       8'hff
`define PORT9_RST_DIRECTION   8'hc0
`define PORT9_RST_FUNCTION    8'h00
`define PORT9_RST_OPEN_DRAIN  2'h0
`define PORT9_RST_OSC_CTRL    1'h0
// ****************************************
// Field positions
// ****************************************
`define PORT9_BIT_TXD0        0
`define PORT9_BIT_RXD0        1
`define PORT9_BIT_SER_CLK0    2
`define PORT9_BIT_TXD1        3
`define PORT9_BIT_RXD1        4
`define PORT9_BIT_SER_CLK1    5
`define PORT9_BIT_OSC_A       6
`define PORT9_BIT_OSC_B       7
`define PORT9_FUNC_MASK       8'h2d
`define PORT9_OD_CH0          0
`define PORT9_OD_CH1          1
`define PORT9_OSC_ENABLE      0
`endif

// *** inc/port9_pkg.sv ***
// Types shared by the port 9 pin function block
package port9_pkg;
    typedef logic [7:0] byte_t;
    typedef enum logic [1:0] {
        PIN_PLAIN,
        PIN_OPEN_DRAIN,
        PIN_OSC
    } pin_kind_t;
endpackage

// *** inc/port9_cfg_if.sv ***
// Configuration bundle passed from the register file to the pin logic
`timescale 1ns/100ps
interface port9_cfg_if;
    import port9_pkg::*;
    byte_t latchVal;
    byte_t dirVal;
    byte_t funcVal;
    logic  [1:0] odEnVal;
    logic  oscEnable;
    modport regs (output latchVal, output dirVal, output funcVal, output odEnVal,
                  output oscEnable);
    modport pins (input latchVal, input dirVal, input funcVal, input odEnVal,
                  input oscEnable);
endinterface

// *** design/port9_regs.sv ***
// Register file of the port 9 block
`timescale 1ns/100ps
`include "port9_params.svh"
module port9_regs
    import port9_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        arst_n,
    input  wire logic [7:0]  addr,
    input  wire logic [7:0]  wrData,
    input  wire logic        wrStrobe,
    input  wire logic        rdStrobe,
    input  wire byte_t       pinLevel,
    output logic      [7:0]  rdData,
    port9_cfg_if.regs        cfg
);
    byte_t latch_reg, latch_next;
    byte_t dir_reg, dir_next;
    byte_t func_reg, func_next;
    logic [1:0] odEn_reg, odEn_next;
    logic osc_reg, osc_next;
    logic [7:0] rd_reg, rd_next;

    // ****************************************
    // Next state of the registers
    // ****************************************
    // Direction and function are write only; whole byte writes only
    always_comb begin
        latch_next = latch_reg;
        dir_next   = dir_reg;
        func_next  = func_reg;
        odEn_next  = odEn_reg;
        osc_next   = osc_reg;
        rd_next    = 8'h00;
        if (wrStrobe) begin
            case (addr)
                `PORT9_IDX_LATCH:      latch_next = wrData;
                `PORT9_IDX_DIRECTION:  dir_next = wrData;
                `PORT9_IDX_FUNCTION:   func_next = wrData & `PORT9_FUNC_MASK;
                `PORT9_IDX_OPEN_DRAIN: odEn_next = wrData[1:0];
                `PORT9_IDX_OSC_CTRL:   osc_next = wrData[`PORT9_OSC_ENABLE];
                default: ;
            endcase
        end
        if (rdStrobe) begin
            case (addr)
                `PORT9_IDX_LATCH:      rd_next = pinLevel;
                `PORT9_IDX_OPEN_DRAIN: rd_next = {6'h00, odEn_reg};
                `PORT9_IDX_OSC_CTRL:   rd_next = {7'h00, osc_reg};
                default:            rd_next = 8'h00;
            endcase
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            latch_reg <= `PORT9_RST_LATCH;
            dir_reg   <= `PORT9_RST_DIRECTION;
            func_reg  <= `PORT9_RST_FUNCTION;
            odEn_reg  <= `PORT9_RST_OPEN_DRAIN;
            osc_reg   <= `PORT9_RST_OSC_CTRL;
            rd_reg    <= 8'h00;
        end else begin
            latch_reg <= latch_next;
            dir_reg   <= dir_next;
            func_reg  <= func_next;
            odEn_reg  <= odEn_next;
            osc_reg   <= osc_next;
            rd_reg    <= rd_next;
        end
    end

    assign rdData        = rd_reg;
    assign cfg.latchVal  = latch_reg;
    assign cfg.dirVal    = dir_reg;
    assign cfg.funcVal   = func_reg;
    assign cfg.odEnVal   = odEn_reg;
    assign cfg.oscEnable = osc_reg;
endmodule

// *** design/port9_pin_cell.sv ***
// One pad cell: port or function output, push-pull or open-drain
`timescale 1ns/100ps
module port9_pin_cell
    import port9_pkg::*;
(
    input  wire logic      portData,
    input  wire logic      portDir,
    input  wire logic      funcSel,
    input  wire logic      funcData,
    input  wire logic      funcDrive,
    input  wire pin_kind_t kind,
    output logic           padOut,
    output logic           padOe
);
    logic value;
    logic drive;

    // Choose the source, then shape the drive by pin kind
    always_comb begin
        if (funcSel && portDir) begin
            value = funcData;
            drive = funcDrive;
        end else begin
            value = portData;
            drive = portDir;
        end
        padOut = 1'b0;
        padOe  = 1'b0;
        case (kind)
            PIN_PLAIN: begin
                padOut = value;
                padOe  = drive;
            end
            PIN_OPEN_DRAIN: begin
                padOut = 1'b0;
                padOe  = drive & ~value;
            end
            PIN_OSC: begin
                padOut = 1'b0;
                padOe  = 1'b0;
            end
            default: begin
                padOut = 1'b0;
                padOe  = 1'b0;
            end
        endcase
    end
endmodule

// *** design/port9_pin_function_mux.sv ***
// Port 9 top: register file, pad cells and serial channel hookup
// Bit map of the port
// bit 0: transmit data of channel zero, push-pull or open-drain
// bit 1: receive data of channel zero, always routed to the channel
// bit 2: clear-to-send input or serial clock of channel zero
// bit 3: transmit data of channel one, push-pull or open-drain
// bit 4: receive data of channel one, always routed to the channel
// bit 5: clear-to-send input or serial clock of channel one
// bit 6: open-drain port bit or oscillator input side
// bit 7: open-drain port bit or oscillator output side
//
// Limitation: the oscillator lives outside; this block only steps aside for it
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/100ps
`include "port9_params.svh"
module port9_pin_function_mux
    import port9_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        arst_n,
    // Register port
    input  wire logic [7:0]  addr,
    input  wire logic [7:0]  wrData,
    input  wire logic        wrStrobe,
    input  wire logic        rdStrobe,
    output logic      [7:0]  rdData,
    // Pads
    input  wire logic [7:0]  padIn,
    output logic      [7:0]  padOut,
    output logic      [7:0]  padOe,
    // Serial channel zero
    input  wire logic        txData0,
    output logic             rxData0,
    output logic             ctsIn0,
    input  wire logic        sclkOut0,
    output logic             sclkIn0,
    // Serial channel one
    input  wire logic        txData1,
    output logic             rxData1,
    output logic             ctsIn1,
    input  wire logic        sclkOut1,
    output logic             sclkIn1,
    // Low-frequency oscillator hookup
    output logic             oscPinsActive,
    output logic             oscInput
);
    // ****************************************
    // Bit positions, named for the helpers
    // ****************************************
    localparam int TxBit0  = `PORT9_BIT_TXD0;
    localparam int RxBit0  = `PORT9_BIT_RXD0;
    localparam int ClkBit0 = `PORT9_BIT_SER_CLK0;
    localparam int TxBit1  = `PORT9_BIT_TXD1;
    localparam int RxBit1  = `PORT9_BIT_RXD1;
    localparam int ClkBit1 = `PORT9_BIT_SER_CLK1;
    localparam int OscBitA = `PORT9_BIT_OSC_A;
    localparam int OscBitB = `PORT9_BIT_OSC_B;
    localparam int NumPins = 8;

    // ****************************************
    // Configuration bundle and per-bit wiring
    // ****************************************
    port9_cfg_if cfg ();
    // Function path per bit, kept as vectors so each stage can be probed
    logic      [7:0] funcData;
    logic      [7:0] funcSel;
    logic      [7:0] funcDrive;
    pin_kind_t       kinds [NumPins];
    // Named views of the configuration, read by the pin logic below
    logic      [7:0] latchBits;
    logic      [7:0] dirBits;
    logic      [7:0] funcBits;
    logic      [1:0] odEnBits;
    logic            oscOn;

    // ****************************************
    // Decoding helpers
    // ****************************************
    // True for bits that own a serial output; select and drive both use it,
    // so a bit can never be handed to a function with no source behind it
    function automatic logic has_out_func(input int bitIdx);
        logic result;
        result = 1'b0;
        case (bitIdx)
            TxBit0:  result = 1'b1;
            ClkBit0: result = 1'b1;
            TxBit1:  result = 1'b1;
            ClkBit1: result = 1'b1;
            // Receive bits have no serial output; they drive only as port bits
            RxBit0:  result = 1'b0;
            RxBit1:  result = 1'b0;
            // Upper bits belong to the oscillator, not to the channels
            OscBitA: result = 1'b0;
            OscBitB: result = 1'b0;
            default: result = 1'b0;
        endcase
        return result;
    endfunction

    // Serial output that feeds a bit; zero where the bit has none
    function automatic logic out_source(
        input int   bitIdx,
        input logic tx0,
        input logic tx1,
        input logic clk0,
        input logic clk1
    );
        logic result;
        result = 1'b0;
        case (bitIdx)
            TxBit0:  result = tx0;
            TxBit1:  result = tx1;
            ClkBit0: result = clk0;
            ClkBit1: result = clk1;
            // A fixed zero keeps unused bits from floating in the cell
            default: result = 1'b0;
        endcase
        return result;
    endfunction

    // Pad kind of a bit from the open-drain enables and the oscillator switch
    function automatic pin_kind_t pin_kind_of(
        input int         bitIdx,
        input logic [1:0] odEn,
        input logic       oscEnOn
    );
        pin_kind_t result;
        result = PIN_PLAIN;
        case (bitIdx)
            TxBit0:  result = odEn[`PORT9_OD_CH0] ? PIN_OPEN_DRAIN : PIN_PLAIN;
            TxBit1:  result = odEn[`PORT9_OD_CH1] ? PIN_OPEN_DRAIN : PIN_PLAIN;
            OscBitA: result = oscEnOn ? PIN_OSC : PIN_OPEN_DRAIN;
            OscBitB: result = oscEnOn ? PIN_OSC : PIN_OPEN_DRAIN;
            default: result = PIN_PLAIN;
        endcase
        return result;
    endfunction

    // ****************************************
    // Register file
    // ****************************************
    // Read data leave from a flop, so the bus always sees one cycle latency
    port9_regs u_regs (
        .clock    (clock),
        .arst_n   (arst_n),
        .addr     (addr),
        .wrData   (wrData),
        .wrStrobe (wrStrobe),
        .rdStrobe (rdStrobe),
        .pinLevel (padIn),
        .rdData   (rdData),
        .cfg      (cfg)
    );

    // ****************************************
    // Configuration views
    // ****************************************
    // Plain copies; they keep the interface names out of the pin logic
    assign latchBits = cfg.latchVal;
    assign dirBits   = cfg.dirVal;
    assign funcBits  = cfg.funcVal;
    assign odEnBits  = cfg.odEnVal;
    assign oscOn     = cfg.oscEnable;

    // ****************************************
    // Per-bit function path and pad cells
    // ****************************************
    // One cell per bit keeps every pin on the same priority path
    for (genvar g = 0; g < NumPins; g++) begin : gen_pin
        assign funcSel[g]   = has_out_func(g) & funcBits[g];
        // A function drives only where it exists; the cell adds the direction
        assign funcDrive[g] = has_out_func(g);
        assign funcData[g]  = out_source(g, txData0, txData1, sclkOut0, sclkOut1);
        assign kinds[g]     = pin_kind_of(g, odEnBits, oscOn);
        port9_pin_cell u_cell (
            .portData  (latchBits[g]),
            .portDir   (dirBits[g]),
            .funcSel   (funcSel[g]),
            .funcData  (funcData[g]),
            .funcDrive (funcDrive[g]),
            .kind      (kinds[g]),
            .padOut    (padOut[g]),
            .padOe     (padOe[g])
        );
    end

    // ****************************************
    // Inputs toward serial channel zero
    // ****************************************
    // receive always fed
    // There is no switch here: a pin read as a plain input still feeds the receiver
    assign rxData0 = padIn[RxBit0];
    // clear to send and clock in
    // Both views share one pin; the channel decides which one it listens to
    assign ctsIn0  = padIn[ClkBit0];
    assign sclkIn0 = padIn[ClkBit0];

    // ****************************************
    // Inputs toward serial channel one
    // ****************************************
    // receive always fed
    assign rxData1 = padIn[RxBit1];
    // clear to send and clock in
    assign ctsIn1  = padIn[ClkBit1];
    assign sclkIn1 = padIn[ClkBit1];

    // ****************************************
    // Low-frequency oscillator hookup
    // ****************************************
    // oscillator sees upper pin
    // Gated so a port level never reaches the oscillator while it is off
    assign oscPinsActive = oscOn;
    assign oscInput      = oscOn & padIn[OscBitA];
endmodule

// *** sim/port9_board.sv ***
// Board model: pad wires with pull-ups and external drivers
`timescale 1ns/100ps
module port9_board (
    input  wire logic [7:0] padOut,
    input  wire logic [7:0] padOe,
    input  wire logic [7:0] extEn,
    input  wire logic [7:0] extVal,
    output logic      [7:0] padIn
);
    // released open drain rises
    // Undriven wires sit on the pull-up, never on a stale value
    assign padIn = (padOe & padOut) | (~padOe & extEn & extVal) | (~padOe & ~extEn);
endmodule

// *** sim/port9_pin_function_mux_asserts.sv ***
// Checker for the port 9 pin function block
`timescale 1ns/100ps
module port9_pin_function_mux_asserts (
    input wire logic       clock,
    input wire logic       arst_n,
    input wire logic [7:0] addr,
    input wire logic [7:0] wrData,
    input wire logic       wrStrobe,
    input wire logic       rdStrobe,
    input wire logic [7:0] rdData,
    input wire logic [7:0] padIn,
    input wire logic [7:0] padOut,
    input wire logic [7:0] padOe,
    input wire logic       rxData0,
    input wire logic       rxData1,
    input wire logic       ctsIn0,
    input wire logic       ctsIn1,
    input wire logic       oscPinsActive,
    input wire logic       oscInput
);
    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);
    // Bus steps
    sequence latchRd; rdStrobe && addr == 8'h19; endsequence
    sequence dirIn; wrStrobe && addr == 8'h1c && wrData[5:0] == 6'h00; endsequence
    sequence woRd; rdStrobe && (addr == 8'h1c || addr == 8'h1d); endsequence
    a_rx_follow: assert property (rxData0 == padIn[1] && rxData1 == padIn[4])
        else $error("receive copy wrong");
    a_cts_follow: assert property (ctsIn0 == padIn[2] && ctsIn1 == padIn[5])
        else $error("cts copy wrong");
    a_read_pins: assert property (latchRd |=> rdData == $past(padIn))
        else $error("latch read not pin level");
    a_read_idle: assert property (!rdStrobe |=> rdData == 8'h00)
        else $error("read data outside slot");
    a_wo_read: assert property (woRd |=> rdData == 8'h00)
        else $error("write only register readable");
    a_upper_od: assert property ((padOe[7:6] & padOut[7:6]) == 2'b00)
        else $error("upper pin driven high");
    a_osc_release: assert property (oscPinsActive |-> padOe[7:6] == 2'b00)
        else $error("osc pins driven");
    a_osc_input: assert property (oscInput == (padIn[6] && oscPinsActive))
        else $error("osc input wrong");
    a_dir_input: assert property (dirIn |=> padOe[5:0] == 6'h00)
        else $error("input pin driven");
endmodule
bind port9_pin_function_mux port9_pin_function_mux_asserts chk (.*);

// *** sim/tb_top.sv ***
// Self-checking bench for the port 9 pin function block
`timescale 1ns/100ps
module tb_top;
    logic       clock, arst_n, wrStrobe, rdStrobe, txData0, txData1, sclkOut0, sclkOut1;
    logic       rxData0, rxData1, ctsIn0, ctsIn1, sclkIn0, sclkIn1, oscPinsActive, oscInput;
    logic [7:0] addr, wrData, rdData, padIn, padOut, padOe, extEn, extVal;
    int         n_errors, checked;
    port9_pin_function_mux DUT (.clock(clock), .arst_n(arst_n), .addr(addr),
        .wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData),
        .padIn(padIn), .padOut(padOut), .padOe(padOe), .txData0(txData0),
        .rxData0(rxData0), .ctsIn0(ctsIn0), .sclkOut0(sclkOut0), .sclkIn0(sclkIn0),
        .txData1(txData1), .rxData1(rxData1), .ctsIn1(ctsIn1), .sclkOut1(sclkOut1),
        .sclkIn1(sclkIn1), .oscPinsActive(oscPinsActive), .oscInput(oscInput));
    port9_board board (.padOut(padOut), .padOe(padOe), .extEn(extEn), .extVal(extVal),
        .padIn(padIn));
    always #5 clock = ~clock;
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        addr <= a;
        wrData <= d;
        wrStrobe <= 1'b1;
        @(posedge clock);
        wrStrobe <= 1'b0;
        #1;
    endtask
    // Read data only stand in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock);
        addr <= a;
        rdStrobe <= 1'b1;
        @(posedge clock);
        rdStrobe <= 1'b0;
        #1 chk(rdData, exp);
    endtask
    task automatic stop_test;
        $display("checked %0d n_errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic t_reset;
        chk(padOe, 8'h00);
        rd(8'h19, 8'hff);
        rd(8'h1c, 8'h00);
        rd(8'h1d, 8'h00);
        rd(8'h00, 8'h00);
        $display("t_reset done");
    endtask
    task automatic t_port_out;
        wr(8'h1c, 8'h3f);
        chk(padOut & padOe, 8'h3f);
        wr(8'h19, 8'h2a);
        chk(padOe, 8'h3f);
        chk(padOut & padOe, 8'h2a);
        rd(8'h19, 8'hea);
        wr(8'h00, 8'h00);
        chk(padOe, 8'h3f);
        $display("t_port_out done");
    endtask
    task automatic t_upper;
        wr(8'h1c, 8'hc0);
        wr(8'h19, 8'h40);
        chk(padOe, 8'h80);
        rd(8'h19, 8'h7f);
        wr(8'h19, 8'h00);
        wr(8'h1f, 8'h01);
        chk(padOe, 8'h00);
        chk({6'h00, oscPinsActive, oscInput}, 8'h03);
        wr(8'h1f, 8'h00);
        chk(padOe, 8'hc0);
        $display("t_upper done");
    endtask
    task automatic t_func;
        @(posedge clock);
        txData0 <= 1'b0;
        txData1 <= 1'b1;
        sclkOut0 <= 1'b1;
        wr(8'h19, 8'hff);
        wr(8'h1c, 8'h00);
        wr(8'h1d, 8'hff);
        chk(padOe, 8'h00);
        wr(8'h1c, 8'h2d);
        chk(padOe, 8'h2d);
        chk(padOut & 8'h2d, 8'h0c);
        wr(8'h1d, 8'h09);
        wr(8'h1e, 8'h03);
        chk(padOe & 8'h09, 8'h01);
        chk(padOut & 8'h01, 8'h00);
        wr(8'h1d, 8'h00);
        wr(8'h1e, 8'h00);
        chk(padOut & 8'h2d, 8'h2d);
        $display("t_func done");
    endtask
    task automatic t_rx;
        wr(8'h1c, 8'h00);
        @(posedge clock);
        extEn <= 8'h36;
        extVal <= 8'h12;
        @(posedge clock);
        #1 chk({sclkIn1, sclkIn0, rxData1, rxData0, ctsIn1, ctsIn0}, 8'h0c);
        rd(8'h19, 8'hdb);
        @(posedge clock);
        extVal <= 8'h24;
        @(posedge clock);
        #1 chk({sclkIn1, sclkIn0, rxData1, rxData0, ctsIn1, ctsIn0}, 8'h33);
        $display("t_rx done");
    endtask
    initial begin
        {clock, arst_n, wrStrobe, rdStrobe, txData0, txData1, sclkOut0, sclkOut1} = 8'h00;
        {addr, wrData, extEn, extVal} = 32'h0000_0000;
        n_errors = 0;
        checked = 0;
        repeat (2) @(posedge clock);
        arst_n <= 1'b1;
        #1 t_reset();
        t_port_out();
        t_upper();
        t_func();
        t_rx();
        stop_test();
    end
    // Watchdog cuts a hang short
    initial begin
        #100000 n_errors++;
        stop_test();
    end
endmodule
